// ===== hdl/adc_rate_timer.sv
// Divides the system clock into modulator sample ticks and frame ends.
// Assumes a single clock domain and a level run enable.
`timescale 1ns/1ps
`default_nettype none
`include "sigma_delta_regs.svh"

module adc_rate_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Settings
  input wire logic run,
  input wire logic [4:0] clock_divider_select,
  input wire logic fast_divide,
  input wire logic single_sample,
  input wire logic [2:0] oversampling_select,
  // Ticks
  output logic sample_tick,
  output logic frame_end
);
  import sigma_delta_pkg::*;

  logic [5:0] pre_count;
  logic [4:0] div_count;
  logic [15:0] frame_count;
  logic direct;
  logic mclk_tick;
  logic clock_divider_select_tick;
  logic [4:0] div_last;
  logic [15:0] frame_total;

  assign direct = (clock_divider_select == `CLOCK_DIRECT_CODE);
  // Master clock is system clock, or system clock / 2 / (field + 1).
  assign mclk_tick = direct || (pre_count == {clock_divider_select, 1'b1});
  assign div_last = fast_divide ? 5'(`DIVIDE_FAST - 1) : 5'(`DIVIDE_SLOW - 1);
  assign clock_divider_select_tick = mclk_tick && (div_count == div_last);
  // Ratio halves per code step; doubling doubles the sample count.
  assign frame_total = 16'(`OSR_BASE >> oversampling_select) << !single_sample;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !run)
    begin
      pre_count <= 6'h00;
      div_count <= 5'h00;
      frame_count <= 16'h0000;
      sample_tick <= 1'b0;
      frame_end <= 1'b0;
    end
    else
    begin
      pre_count <= mclk_tick ? 6'h00 : pre_count + 6'h01;
      if (mclk_tick)
      begin
        div_count <= clock_divider_select_tick ? 5'h00 : div_count + 5'h01;
      end
      if (clock_divider_select_tick)
      begin
        frame_count <= (frame_count == frame_total - 16'h0001) ? 16'h0000
                       : frame_count + 16'h0001;
      end
      sample_tick <= clock_divider_select_tick;
      // Result rate is master clock / (divide x doubling x ratio).
      frame_end <= clock_divider_select_tick && (frame_count == frame_total - 16'h0001);
    end
  end

endmodule : adc_rate_timer
`default_nettype wire

// ===== hdl/sigma_delta_adc_config_regs.sv
// Control registers of a 24-bit delta-sigma converter front end, on AXI4-Lite.
// Assumes one clock, an analog partner that takes the registered controls,
// and a modulator bit stream that arrives asynchronously.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sigma_delta_regs.svh"

module sigma_delta_adc_config_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output sigma_delta_pkg::resp_type bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output sigma_delta_pkg::resp_type rresp,
  // Modulator stream
  input wire logic modulator_bit,
  output logic modulator_sample,
  output logic converter_active,
  // Power supply controls
  output logic bandgap_on,
  output logic regulator_output_enable,
  output logic regulator_pulldown,
  output logic regulator_bypass,
  output logic [1:0] regulator_voltage_select,
  output logic common_mode_voltage_oe,
  output logic reference_external,
  // Gain and input controls
  output logic [1:0] reference_gain_shift,
  output logic [1:0] converter_gain_shift,
  output logic [2:0] amplifier_gain_select,
  output logic input_short_connect,
  output logic [1:0] input_cross_select,
  output logic offset_negative,
  output logic [1:0] offset_quarters,
  output logic [2:0] positive_channel_select,
  output logic [2:0] negative_channel_select,
  // Operational amplifier controls
  output logic opamp_enable,
  output logic [1:0] opamp_negative_select,
  output logic [1:0] opamp_positive_select
);
  import sigma_delta_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic reg_sel_type decode(input logic [7:0] addr);
    case (addr)
      `OFS_POWER_SUPPLY_CONTROL: decode = SEL_POWER;
      `OFS_GAIN_SELECT: decode = SEL_GAIN;
      `OFS_INPUT_CONNECTION_OFFSET: decode = SEL_INPUT;
      `OFS_CHANNEL_SELECT: decode = SEL_CHANNEL;
      `OFS_RESULT_LOW_BYTE: decode = SEL_RES_LOW;
      `OFS_RESULT_MIDDLE_BYTE: decode = SEL_RES_MID;
      `OFS_RESULT_HIGH_BYTE: decode = SEL_RES_HIGH;
      `OFS_CONVERTER_CONTROL_A: decode = SEL_CTRL_A;
      `OFS_CONVERTER_CONTROL_B: decode = SEL_CTRL_B;
      `OFS_CONVERTER_CLOCK_SELECT: decode = SEL_CLOCK;
      `OFS_OPAMP_CONTROL: decode = SEL_OPAMP;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  reg_byte_type power_supply_control;
  reg_byte_type gain_select;
  reg_byte_type input_connection_offset;
  reg_byte_type channel_select;
  reg_byte_type converter_control_a;
  reg_byte_type converter_control_b;
  reg_byte_type converter_clock_select;
  reg_byte_type opamp_control;
  reg_byte_type result_low_byte;
  reg_byte_type result_middle_byte;
  reg_byte_type result_high_byte;
  logic end_of_conversion;

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  reg_byte_type w_byte;
  logic w_lane;
  logic commit;
  reg_sel_type wr_sel;
  logic wr_en;
  reg_sel_type rd_sel;
  reg_byte_type rd_byte;

  logic [2:0] bit_sync;
  logic stream_bit;
  logic run;
  logic sample_tick;
  logic frame_end;
  logic [23:0] result;
  logic result_valid;

  // ****************************************************************
  // Write channel
  // ****************************************************************
  // Address and data are taken independently and committed together.
  assign commit = aw_held && w_held && !bvalid;
  assign wr_sel = decode(aw_addr);
  assign wr_en = commit && w_lane;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      awready <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end
    else
    begin
      if (commit)
      begin
        aw_held <= 1'b0;
      end
      awready <= !aw_held && !bvalid;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wready <= 1'b0;
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      wready <= 1'b0;
      w_held <= 1'b1;
      w_byte <= wdata[7:0];
      w_lane <= wstrb[0];
    end
    else
    begin
      if (commit)
      begin
        w_held <= 1'b0;
      end
      wready <= !w_held && !bvalid;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (commit)
    begin
      bvalid <= 1'b1;
      bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Only implemented bits are stored; the rest read back as zero, except bit 1 of control B, which reads the end flag.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      power_supply_control <= `RST_CONFIG;
      gain_select <= `RST_CONFIG;
      input_connection_offset <= `RST_CONFIG;
      channel_select <= `RST_CONFIG;
      converter_control_a <= `RST_CONVERTER_CONTROL_A;
      converter_control_b <= `RST_CONFIG;
      converter_clock_select <= `RST_CONFIG;
      opamp_control <= `RST_CONFIG;
    end
    else if (wr_en)
    begin
      case (wr_sel)
        SEL_POWER: power_supply_control <= w_byte & `MASK_POWER_SUPPLY_CONTROL;
        SEL_GAIN: gain_select <= w_byte & `MASK_GAIN_SELECT;
        SEL_INPUT: input_connection_offset <= w_byte & `MASK_INPUT_CONNECTION_OFFSET;
        SEL_CHANNEL: channel_select <= w_byte & `MASK_CHANNEL_SELECT;
        SEL_CTRL_A: converter_control_a <= w_byte & `MASK_CONVERTER_CONTROL_A;
        SEL_CTRL_B: converter_control_b <= w_byte & `MASK_CONVERTER_CONTROL_B;
        SEL_CLOCK: converter_clock_select <= w_byte & `MASK_CONVERTER_CLOCK_SELECT;
        SEL_OPAMP: opamp_control <= w_byte & `MASK_OPAMP_CONTROL;
        default:
        begin
        end
      endcase
    end
  end

  // Software may only clear the end flag; a new result in the same cycle wins.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      end_of_conversion <= 1'b0;
    end
    else if (result_valid)
    begin
      end_of_conversion <= 1'b1;
    end
    else if (wr_en && wr_sel == SEL_CTRL_B && !w_byte[`BIT_END_OF_CONVERSION])
    begin
      end_of_conversion <= 1'b0;
    end
  end

  // ****************************************************************
  // Result registers
  // ****************************************************************
  // Filled only by the decimator; bus writes never reach them.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      result_low_byte <= `RST_RESULT;
      result_middle_byte <= `RST_RESULT;
      result_high_byte <= `RST_RESULT;
    end
    else if (result_valid)
    begin
      result_low_byte <= result[7:0];
      result_middle_byte <= result[15:8];
      result_high_byte <= result[23:16];
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  assign rd_sel = decode(araddr);

  always_comb
  begin
    case (rd_sel)
      SEL_POWER: rd_byte = power_supply_control;
      SEL_GAIN: rd_byte = gain_select;
      SEL_INPUT: rd_byte = input_connection_offset;
      SEL_CHANNEL: rd_byte = channel_select;
      SEL_RES_LOW: rd_byte = result_low_byte;
      SEL_RES_MID: rd_byte = result_middle_byte;
      SEL_RES_HIGH: rd_byte = result_high_byte;
      SEL_CTRL_A: rd_byte = converter_control_a;
      SEL_CTRL_B: rd_byte = converter_control_b | {6'h00, end_of_conversion, 1'b0};
      SEL_CLOCK: rd_byte = converter_clock_select;
      SEL_OPAMP: rd_byte = opamp_control;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else
    begin
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
      end
      arready <= !rvalid;
    end
  end

  // ****************************************************************
  // Modulator stream input
  // ****************************************************************
  // The stream settles only when the last two stages agree.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      bit_sync <= 3'h0;
      stream_bit <= 1'b0;
    end
    else
    begin
      bit_sync <= {bit_sync[1:0], modulator_bit};
      if (bit_sync[2] == bit_sync[1])
      begin
        stream_bit <= bit_sync[2];
      end
    end
  end

  // Power-off overrides sleep and soft reset; any of them stops conversion.
  assign run = !converter_control_a[`BIT_POWER_OFF] && !converter_control_a[`BIT_SLEEP]
               && !converter_control_a[`BIT_SOFT_RESET];

  adc_rate_timer adc_rate_timer_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(run),
    .clock_divider_select(converter_clock_select[4:0]),
    .fast_divide(converter_control_b[7]),
    .single_sample(converter_control_b[5]),
    .oversampling_select(converter_control_a[4:2]),
    .sample_tick(sample_tick),
    .frame_end(frame_end)
  );

  sinc_decimator sinc_decimator_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(run),
    .single_sample(converter_control_b[5]),
    .oversampling_select(converter_control_a[4:2]),
    .sample_tick(sample_tick),
    .frame_end(frame_end),
    .stream_bit(stream_bit),
    .result(result),
    .result_valid(result_valid)
  );

  // ****************************************************************
  // Power supply, reference and converter outputs
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      bandgap_on <= 1'b0;
      regulator_output_enable <= 1'b0;
      regulator_pulldown <= 1'b1;
      common_mode_voltage_oe <= 1'b0;
      regulator_bypass <= 1'b0;
      regulator_voltage_select <= 2'h0;
      converter_active <= 1'b0;
      modulator_sample <= 1'b0;
      reference_external <= 1'b0;
    end
    else
    begin
      bandgap_on <= power_supply_control[`BIT_REGULATOR_ENABLE]
                    || !converter_control_a[`BIT_POWER_OFF];
      regulator_output_enable <= power_supply_control[`BIT_REGULATOR_ENABLE];
      regulator_pulldown <= !power_supply_control[`BIT_REGULATOR_ENABLE];
      // Common mode follows the bandgap; off means the pin is left floating.
      common_mode_voltage_oe <= power_supply_control[`BIT_REGULATOR_ENABLE]
                                || !converter_control_a[`BIT_POWER_OFF];
      regulator_bypass <= power_supply_control[`BIT_REGULATOR_BYPASS];
      regulator_voltage_select <= power_supply_control[1:0];
      converter_active <= run;
      modulator_sample <= sample_tick;
      reference_external <= converter_control_a[`BIT_REFERENCE_EXTERNAL];
    end
  end

  // ****************************************************************
  // Gain, input, channel and opamp outputs
  // ****************************************************************
  // Reserved gain code 11 falls back to unity so the stage never overdrives.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      reference_gain_shift <= 2'h0;
      converter_gain_shift <= 2'h0;
      amplifier_gain_select <= 3'h0;
      input_short_connect <= 1'b0;
      input_cross_select <= 2'h0;
      offset_negative <= 1'b0;
      offset_quarters <= 2'h0;
      positive_channel_select <= 3'h0;
      negative_channel_select <= 3'h0;
      opamp_enable <= 1'b0;
      opamp_negative_select <= 2'h0;
      opamp_positive_select <= 2'h0;
    end
    else
    begin
      reference_gain_shift <= (gain_select[6:5] == 2'h3) ? 2'h0 : gain_select[6:5];
      converter_gain_shift <= (gain_select[4:3] == 2'h3) ? 2'h0 : gain_select[4:3];
      amplifier_gain_select <= gain_select[2:0];
      input_short_connect <= input_connection_offset[`BIT_INPUT_SHORT];
      input_cross_select <= input_connection_offset[5:4];
      // Codes 000 and 100 both mean zero offset; the sign then is moot.
      offset_quarters <= input_connection_offset[2:1];
      offset_negative <= input_connection_offset[3]
                         && (input_connection_offset[2:1] != 2'h0);
      positive_channel_select <= channel_select[2:0];
      negative_channel_select <= channel_select[5:3];
      opamp_enable <= opamp_control[`BIT_OPAMP_ENABLE];
      opamp_negative_select <= opamp_control[3:2];
      opamp_positive_select <= opamp_control[1:0];
    end
  end

endmodule : sigma_delta_adc_config_regs
`default_nettype wire

// ===== hdl/sinc_decimator.sv
// First-order sinc decimator: counts ones of the modulator stream per frame.
// Assumes sample_tick and frame_end come from adc_rate_timer, same clock.
`timescale 1ns/1ps
`default_nettype none

module sinc_decimator (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic single_sample,
  input wire logic [2:0] oversampling_select,
  // Stream
  input wire logic sample_tick,
  input wire logic frame_end,
  input wire logic stream_bit,
  // Result
  output logic [23:0] result,
  output logic result_valid
);
  import sigma_delta_pkg::*;

  logic [15:0] ones;
  logic [15:0] ones_total;
  logic [4:0] shift;
  logic [31:0] scaled;

  assign ones_total = ones + {15'h0000, stream_bit};
  // Full scale of a frame is 2^15 down to 2^7 counts; scale to 24 bits.
  assign shift = 5'h09 + {2'h0, oversampling_select} + {4'h0, single_sample};
  assign scaled = {16'h0000, ones_total} << shift;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !run)
    begin
      ones <= 16'h0000;
      result <= 24'h000000;
      result_valid <= 1'b0;
    end
    else
    begin
      result_valid <= 1'b0;
      if (sample_tick)
      begin
        // The last tick of a frame is folded in and the count restarts.
        ones <= frame_end ? 16'h0000 : ones_total;
      end
      if (sample_tick && frame_end)
      begin
        // An all-ones frame saturates rather than wrapping to zero.
        result <= (scaled[31:24] != 8'h00) ? 24'hFFFFFF : scaled[23:0];
        result_valid <= 1'b1;
      end
    end
  end

endmodule : sinc_decimator
`default_nettype wire

// ===== shared/sigma_delta_pkg.sv
// Types shared by the delta-sigma converter control block.
// Assumes nothing of its surroundings.
package sigma_delta_pkg;

  typedef logic [7:0] reg_byte_type;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } resp_type;

  typedef enum {
    SEL_POWER,
    SEL_GAIN,
    SEL_INPUT,
    SEL_CHANNEL,
    SEL_RES_LOW,
    SEL_RES_MID,
    SEL_RES_HIGH,
    SEL_CTRL_A,
    SEL_CTRL_B,
    SEL_CLOCK,
    SEL_OPAMP,
    SEL_NONE
  } reg_sel_type;

endpackage : sigma_delta_pkg

// ===== shared/sigma_delta_regs.svh
// Register offsets, field positions, masks, reset values and timing counts
// for the delta-sigma converter control block.
// Assumes the includer compares them against an 8-bit byte address.
`ifndef SIGMA_DELTA_REGS_SVH
`define SIGMA_DELTA_REGS_SVH

// ****************************************************************
// Byte offsets on the register bus
// ****************************************************************
`define OFS_POWER_SUPPLY_CONTROL 8'h00
`define OFS_GAIN_SELECT 8'h04
`define OFS_INPUT_CONNECTION_OFFSET 8'h08
`define OFS_CHANNEL_SELECT 8'h0C
`define OFS_RESULT_LOW_BYTE 8'h10
`define OFS_RESULT_MIDDLE_BYTE 8'h14
`define OFS_RESULT_HIGH_BYTE 8'h18
`define OFS_CONVERTER_CONTROL_A 8'h1C
`define OFS_CONVERTER_CONTROL_B 8'h20
`define OFS_CONVERTER_CLOCK_SELECT 8'h24
`define OFS_OPAMP_CONTROL 8'h28

// ****************************************************************
// Implemented bits and reset values
// ****************************************************************
`define MASK_POWER_SUPPLY_CONTROL 8'h87
`define MASK_GAIN_SELECT 8'h7F
`define MASK_INPUT_CONNECTION_OFFSET 8'h7E
`define MASK_CHANNEL_SELECT 8'h3F
`define MASK_CONVERTER_CONTROL_A 8'hFD
`define MASK_CONVERTER_CONTROL_B 8'hFC
`define MASK_CONVERTER_CLOCK_SELECT 8'h1F
`define MASK_OPAMP_CONTROL 8'h8F
`define RST_CONFIG 8'h00
`define RST_CONVERTER_CONTROL_A 8'h20
`define RST_RESULT 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_REGULATOR_ENABLE 7
`define BIT_REGULATOR_BYPASS 2
`define BIT_SOFT_RESET 7
`define BIT_SLEEP 6
`define BIT_POWER_OFF 5
`define BIT_REFERENCE_EXTERNAL 0
`define BIT_END_OF_CONVERSION 1
`define BIT_INPUT_SHORT 6
`define BIT_OPAMP_ENABLE 7

// ****************************************************************
// Timing counts
// ****************************************************************
`define DIVIDE_SLOW 30
`define DIVIDE_FAST 12
`define OSR_BASE 16384
`define CLOCK_DIRECT_CODE 5'h1F

`endif

// ===== verification/modulator_model.sv
// Stand-in for the modulator: a half-density bit stream.
// Assumes one sample tick per converter clock.
`timescale 1ns/1ps
`default_nettype none
module modulator_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Stream
  input wire logic modulator_sample,
  output logic modulator_bit
);
  // Toggling per tick gives an exact count in any whole even frame.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      modulator_bit <= 1'b0;
    else if (modulator_sample)
      modulator_bit <= !modulator_bit;
  end
endmodule : modulator_model
`default_nettype wire

// ===== verification/sigma_delta_adc_config_regs_test.sv
// Self-checking bench for the converter register block.
// Assumes design, package, header, model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("FAIL %0t %h %h", $time, a, b); end end
module sigma_delta_adc_config_regs_test;
  import sigma_delta_pkg::*;
  logic ref_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, modulator_sample, modulator_bit, bandgap_on;
  logic regulator_output_enable, regulator_pulldown, regulator_bypass, common_mode_voltage_oe;
  logic input_short_connect, offset_negative;
  logic converter_active, reference_external, opamp_enable;
  logic [1:0] input_cross_select, opamp_negative_select, opamp_positive_select;
  logic [15:0] ticks = 16'h0000, n;
  logic [7:0] awaddr = 0, araddr = 0, d;
  logic [31:0] wdata = 0, rdata;
  resp_type bresp, rresp;
  logic [1:0] regulator_voltage_select, reference_gain_shift, converter_gain_shift;
  logic [1:0] offset_quarters;
  logic [2:0] amplifier_gain_select, positive_channel_select, negative_channel_select;
  logic [33:0] q[$], x;
  int bad_count = 0, tests_run = 0, cyc = 0;
  sigma_delta_adc_config_regs sigma_delta_adc_config_regs_inst (.*, .awprot(3'h0),
    .arprot(3'h0), .wstrb(4'hF));
  modulator_model modulator_model_inst (.*);
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
    logic aw = 1'b1, w = 1'b1;
    q.push_back({r, 32'h0});
    awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= {24'h0, v};
    while (aw || w)
    begin
      @(posedge ref_clk);
      if (aw && awready) begin awvalid <= 0; aw = 0; end
      if (w && wready) begin wvalid <= 0; w = 0; end
    end
    do @(posedge ref_clk); while (!bvalid);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
    q.push_back({r, 24'h0, v});
    arvalid <= 1; araddr <= a;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 0;
    do @(posedge ref_clk); while (!rvalid);
  endtask : rd
  always #4 ref_clk = !ref_clk;
  // Answers are checked where they appear, against the oldest note.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    ticks <= ticks + 16'(modulator_sample);
    if (cyc == 12000) begin bad_count++; end_sim; end
    if (bvalid && bready) begin x = q.pop_front(); `CHK({bresp, 32'h0}, x) end
    if (rvalid && rready) begin x = q.pop_front(); `CHK({rresp, rdata}, x) end
  end
  initial
  begin
    void'($urandom(32'h59b2));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1; bready <= 1; rready <= 1;
    @(posedge ref_clk);
    rd(8'h1C, 8'h20, 2'b00);
    rd(8'h18, 8'h00, 2'b00);
    rd(8'h2C, 8'h00, 2'b10);
    wr(8'h2C, 8'hFF, 2'b10);
    $display("reset test end");
    repeat (8)
    begin
      d = 8'($urandom);
      wr(8'h00, d, 2'b00);
      rd(8'h00, d & 8'h87, 2'b00);
      `CHK({regulator_output_enable, regulator_bypass, regulator_voltage_select},
        {d[7], d[2], d[1:0]})
      wr(8'h04, d, 2'b00);
      rd(8'h04, d & 8'h7F, 2'b00);
      `CHK(amplifier_gain_select, d[2:0])
      `CHK(reference_gain_shift, d[6:5] == 2'h3 ? 2'h0 : d[6:5])
      `CHK(converter_gain_shift, d[4:3] == 2'h3 ? 2'h0 : d[4:3])
      wr(8'h08, d, 2'b00);
      rd(8'h08, d & 8'h7E, 2'b00);
      `CHK({input_short_connect, input_cross_select, offset_negative, offset_quarters},
        {d[6:4], d[3] && d[2:1] != 2'h0, d[2:1]})
      wr(8'h0C, d, 2'b00);
      rd(8'h0C, d & 8'h3F, 2'b00);
      `CHK({negative_channel_select, positive_channel_select}, d[5:0])
      wr(8'h28, d, 2'b00);
      rd(8'h28, d & 8'h8F, 2'b00);
      `CHK({opamp_enable, opamp_negative_select, opamp_positive_select}, {d[7], d[3:0]})
    end
    $display("field test end");
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h00, {k[1], 7'h0}, 2'b00);
      wr(8'h1C, {2'h0, k[0], 5'h1C}, 2'b00);
      repeat (2) @(posedge ref_clk);
      `CHK({bandgap_on, common_mode_voltage_oe, regulator_output_enable, converter_active},
        {{2{k[1] | !k[0]}}, k[1], !k[0]})
    end
    $display("power test end");
    wr(8'h20, 8'hA0, 2'b00);
    wr(8'h24, 8'h1F, 2'b00);
    wr(8'h1C, 8'h1D, 2'b00);
    // Two whole frames of 1536 clocks fit in this wait.
    repeat (3500) @(posedge ref_clk);
    `CHK({converter_active, reference_external}, 2'h3)
    wr(8'h18, 8'h12, 2'b00);
    rd(8'h10, 8'h00, 2'b00);
    rd(8'h14, 8'h00, 2'b00);
    rd(8'h18, 8'h80, 2'b00);
    rd(8'h20, 8'hA2, 2'b00);
    $display("conversion test end");
    wr(8'h20, 8'h00, 2'b00);
    rd(8'h20, 8'h00, 2'b00);
    wr(8'h24, 8'h01, 2'b00);
    // Divide 30 on a quarter-rate master clock gives a tick every 120 clocks.
    repeat (200) @(posedge ref_clk);
    n = ticks;
    repeat (1200) @(posedge ref_clk);
    `CHK(16'(ticks - n), 16'h000A)
    $display("rate test end");
    end_sim;
  end
endmodule : sigma_delta_adc_config_regs_test
bind sigma_delta_adc_config_regs sigma_delta_asserts sigma_delta_asserts_inst (.*);
`default_nettype wire

// ===== verification/sigma_delta_asserts.sv
// Checker for the converter register block.
// Assumes it is bound to that block and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sigma_delta_asserts (
  // Watched ports
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic bandgap_on,
  input wire logic common_mode_voltage_oe,
  input wire logic regulator_output_enable,
  input wire logic regulator_pulldown,
  input wire logic [1:0] reference_gain_shift,
  input wire logic converter_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // A finished read frees the address port two edges later.
  sequence read_done;
    rvalid && rready;
  endsequence
  sequence read_reopen;
    !rvalid ##1 arready;
  endsequence
  chk_pull_inverse: assert property (regulator_pulldown != regulator_output_enable)
    else $error("pulldown wrong");
  chk_cm_follows: assert property (common_mode_voltage_oe == bandgap_on)
    else $error("common mode wrong");
  chk_reg_bandgap: assert property (regulator_output_enable |-> bandgap_on)
    else $error("bandgap off");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("no read answer");
  chk_read_single: assert property (arvalid && arready |=> !arready)
    else $error("second read taken");
  chk_rdata_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper data set");
  chk_bresp_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("response stuck");
  chk_ref_reserved: assert property (reference_gain_shift != 2'h3)
    else $error("reserved gain");
  chk_read_reopen: assert property (read_done |=> read_reopen)
    else $error("read port not reopened");
  chk_active_powered: assert property (converter_active |-> bandgap_on)
    else $error("converter runs unpowered");
endmodule : sigma_delta_asserts
`default_nettype wire
